// ### src/gsp_device.sv
`timescale 1ns/1ps
`include "gsp_consts.svh"
// Functional notes
// R1 - Slave only on four-wire serial link
// R2 - Master ignores output during writes
// R3 - Master clock at most five megahertz
// R4 - Both ends use clock mode three
// R5 - Master drives select low per transfer
// R6 - Clock idles high while select high
// R7 - Receiver samples data on rising edge
// R8 - Bursts accepted outside standby
// R9 - Standby allows single register only
// R10 - Master raises select between commands
// R11 - Ten microsecond gap above one megahertz
// R12 - Sixteen or more clocks per transaction
// R13 - First bit one reads, zero writes
// R14 - Write stores data at address
// R15 - Read returns addressed register
// R16 - Writing 0x02 to 0x10 starts measuring
// R17 - Registers take reset values
// R18 - Three identification codes are constant
// R19 - Revision register reports silicon revision
// R20 - Serial number bytes, low first
// R21 - Temperature split high nibble, low byte
// R22 - Power bits: measure and temp enable
// R23 - Sync 01 drives ready until read
// R24 - Writes to read-only registers ignored
module gsp_device
  import gsp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial link
  gsp_if.dev link,
  // Sensor side
  input wire logic sample_valid,
  input wire logic [15:0] rate_x,
  input wire logic [15:0] rate_y,
  input wire logic [11:0] temp,
  // Status
  output logic measure_mode,
  output logic temp_sensor_enable,
  output logic [7:0] filter_cfg,
  output logic ready_or_analog_select_pin
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Three stages; a change counts when stages two and three agree
  logic [2:0] cs_sy_reg, ck_sy_reg, di_sy_reg;
  logic cs_reg, ck_reg, di_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cs_sy_reg <= 3'h7;
      ck_sy_reg <= 3'h7;
      di_sy_reg <= 3'h0;
      cs_reg <= 1'b1;
      ck_reg <= 1'b1;
      di_reg <= 1'b0;
    end else begin
      cs_sy_reg <= {cs_sy_reg[1:0], link.cs_n};
      ck_sy_reg <= {ck_sy_reg[1:0], link.sclk};
      di_sy_reg <= {di_sy_reg[1:0], link.mosi};
      if (cs_sy_reg[1] == cs_sy_reg[2]) cs_reg <= cs_sy_reg[2];
      if (ck_sy_reg[1] == ck_sy_reg[2]) ck_reg <= ck_sy_reg[2];
      if (di_sy_reg[1] == di_sy_reg[2]) di_reg <= di_sy_reg[2];
    end
  end
  wire logic ck_stable = (ck_sy_reg[1] == ck_sy_reg[2]);
  wire logic sel = ~cs_reg;
  wire logic ck_rise = sel & ck_stable & ck_sy_reg[2] & ~ck_reg; // R4 R7
  wire logic ck_fall = sel & ck_stable & ~ck_sy_reg[2] & ck_reg; // R4
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] pwr_reg, filt_reg, sync_reg;
  logic [15:0] rx_reg, ry_reg;
  logic [11:0] tmp_reg;
  logic rdy_reg;
  // ----------------------------------------
  // Shift engine
  // ----------------------------------------
  logic [7:0] sh_reg;
  logic [2:0] bit_reg;
  logic rw_reg, hdr_reg, first_reg;
  logic [6:0] addr_reg;
  logic [7:0] tx_reg;
  wire logic byte_done = ck_rise & (bit_reg == 3'h7); // R12
  wire logic [7:0] rx_byte = {sh_reg[6:0], di_reg};
  wire logic [6:0] hdr_addr = rx_byte[6:0];
  // Standby: only the first data byte of a transfer is served
  wire logic standby = ~pwr_reg[`GSP_PWR_MEAS_BIT];
  wire logic data_ok = first_reg | ~standby; // R8 R9
  wire logic do_wr = byte_done & ~hdr_reg & ~rw_reg & data_ok; // R13 R14
  wire logic [6:0] rd_addr = hdr_reg ? hdr_addr : addr_reg + 7'h1;

  function automatic logic [7:0] rd_mux(input logic [6:0] a,
      input logic [7:0] p, input logic [7:0] f, input logic [7:0] s,
      input logic [15:0] x, input logic [15:0] y, input logic [11:0] t);
    logic [31:0] sn;
    sn = `GSP_SERIAL_VAL;
    unique case (a)
      `GSP_A_VENDOR: rd_mux = `GSP_VENDOR_VAL; // R18
      `GSP_A_TECH: rd_mux = `GSP_TECH_VAL; // R18
      `GSP_A_PART: rd_mux = `GSP_PART_VAL; // R18
      `GSP_A_REV: rd_mux = `GSP_REV_VAL; // R19
      `GSP_A_SN0: rd_mux = sn[7:0]; // R20
      `GSP_A_SN1: rd_mux = sn[15:8]; // R20
      `GSP_A_SN2: rd_mux = sn[23:16]; // R20
      `GSP_A_SN3: rd_mux = sn[31:24]; // R20
      `GSP_A_RXL: rd_mux = x[7:0];
      `GSP_A_RXH: rd_mux = x[15:8];
      `GSP_A_RYL: rd_mux = y[7:0];
      `GSP_A_RYH: rd_mux = y[15:8];
      `GSP_A_TL: rd_mux = t[7:0]; // R21
      `GSP_A_TH: rd_mux = {4'h0, t[11:8]}; // R21
      `GSP_A_RSV0E: rd_mux = `GSP_RSV0E_VAL;
      `GSP_A_RSV0F: rd_mux = `GSP_RSV0F_VAL;
      `GSP_A_PWR: rd_mux = p;
      `GSP_A_FILT: rd_mux = f;
      `GSP_A_SYNC: rd_mux = s;
      default: rd_mux = 8'h00;
    endcase
  endfunction
  // Load waits for the falling edge after a byte so miso never moves while
  // sclk is high; addr_reg already names the byte about to go out
  wire logic [7:0] rd_data =
    rd_mux(addr_reg, pwr_reg, filt_reg, sync_reg, rx_reg, ry_reg, tmp_reg);
  wire logic tx_slot = ck_fall & (bit_reg == 3'h0);
  wire logic load_tx = tx_slot & rw_reg & ~hdr_reg & data_ok; // R8 R9 R15

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sh_reg <= 8'h00;
      bit_reg <= 3'h0;
      rw_reg <= 1'b0;
      hdr_reg <= 1'b1;
      first_reg <= 1'b0;
      addr_reg <= 7'h00;
      tx_reg <= 8'h00;
    end else if (!sel) begin
      bit_reg <= 3'h0;
      hdr_reg <= 1'b1;
      first_reg <= 1'b0;
      tx_reg <= 8'h00;
    end else begin
      if (ck_rise) begin
        sh_reg <= rx_byte;
        bit_reg <= bit_reg + 3'h1;
        if (bit_reg == 3'h0 && hdr_reg) rw_reg <= di_reg; // R13
      end
      if (byte_done) begin
        hdr_reg <= 1'b0;
        first_reg <= hdr_reg;
        addr_reg <= rd_addr; // R14 R15
      end
      // Bytes refused in standby shift out as zero
      if (load_tx) tx_reg <= rd_data; // R15
      else if (tx_slot) tx_reg <= 8'h00;
      else if (ck_fall) tx_reg <= {tx_reg[6:0], 1'b0}; // R4
    end
  end
  // Data changes on the falling edge so the master samples it rising
  assign link.miso = tx_reg[7]; // R4 R15
  assign link.miso_oe_n = cs_reg; // R1

  // ----------------------------------------
  // Writable registers and data capture
  // ----------------------------------------
  // Unused reserved bits are masked so they always read zero
  wire logic [7:0] wd = rx_byte;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pwr_reg <= `GSP_PWR_RST; // R17
      filt_reg <= `GSP_FILT_RST; // R17
      sync_reg <= `GSP_SYNC_RST; // R17
    end else if (do_wr) begin
      // Other addresses are read-only or reserved and keep their value
      unique case (addr_reg)
        `GSP_A_PWR: pwr_reg <= wd & `GSP_PWR_MASK; // R16 R22
        `GSP_A_FILT: filt_reg <= wd & `GSP_FILT_MASK; // R14
        `GSP_A_SYNC: sync_reg <= wd & `GSP_SYNC_MASK; // R14
        default: ; // R24
      endcase
    end
  end

  // Rates and temperature freeze during a transfer so a burst is coherent
  wire logic rd_done = byte_done & rw_reg & ~hdr_reg & data_ok &
                       (addr_reg >= `GSP_A_RXL) & (addr_reg <= `GSP_A_TH);
  wire logic capture = sample_valid & ~standby & ~sel;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_reg <= 16'h0000;
      ry_reg <= 16'h0000;
      tmp_reg <= 12'h000;
      rdy_reg <= 1'b0;
    end else begin
      if (capture) begin
        rx_reg <= rate_x;
        ry_reg <= rate_y;
        if (pwr_reg[`GSP_PWR_TSM_BIT]) tmp_reg <= temp; // R22
      end
      // New data wins over a read clear in the same cycle
      if (capture) rdy_reg <= 1'b1; // R23
      else if (rd_done) rdy_reg <= 1'b0; // R23
    end
  end
  assign ready_or_analog_select_pin =
    rdy_reg & (sync_reg[1:0] == `GSP_SYNC_READY); // R23
  assign measure_mode = pwr_reg[`GSP_PWR_MEAS_BIT]; // R22
  assign temp_sensor_enable = pwr_reg[`GSP_PWR_TSM_BIT]; // R22
  assign filter_cfg = filt_reg;
endmodule // gsp_device

// ### common/gsp_consts.svh
`ifndef GSP_CONSTS_SVH
`define GSP_CONSTS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define GSP_A_VENDOR 7'h00
`define GSP_A_TECH 7'h01
`define GSP_A_PART 7'h02
`define GSP_A_REV 7'h03
`define GSP_A_SN0 7'h04
`define GSP_A_SN1 7'h05
`define GSP_A_SN2 7'h06
`define GSP_A_SN3 7'h07
`define GSP_A_RXL 7'h08
`define GSP_A_RXH 7'h09
`define GSP_A_RYL 7'h0a
`define GSP_A_RYH 7'h0b
`define GSP_A_TL 7'h0c
`define GSP_A_TH 7'h0d
`define GSP_A_RSV0E 7'h0e
`define GSP_A_RSV0F 7'h0f
`define GSP_A_PWR 7'h10
`define GSP_A_FILT 7'h11
`define GSP_A_SYNC 7'h12
// ----------------------------------------
// Values and fields (identity codes arbitrary)
// ----------------------------------------
`define GSP_VENDOR_VAL 8'h5a
`define GSP_TECH_VAL 8'h3c
`define GSP_PART_VAL 8'h71
`define GSP_REV_VAL 8'h01
`define GSP_SERIAL_VAL 32'h1234_5678
`define GSP_RSV0E_VAL 8'h00
`define GSP_RSV0F_VAL 8'h03
`define GSP_PWR_RST 8'h00
`define GSP_FILT_RST 8'h00
`define GSP_SYNC_RST 8'h00
`define GSP_PWR_MASK 8'h03
`define GSP_FILT_MASK 8'hf7
`define GSP_SYNC_MASK 8'h03
`define GSP_PWR_MEAS_BIT 1
`define GSP_PWR_TSM_BIT 0
`define GSP_SYNC_READY 2'h1
// ----------------------------------------
// Timing (125 MHz clock, master divider)
// ----------------------------------------
`define GSP_CLK_NS 8
`define GSP_SCLK_HALF_NS 104
`define GSP_SCLK_HALF_CYC ((`GSP_SCLK_HALF_NS + `GSP_CLK_NS - 1) / `GSP_CLK_NS)
`define GSP_GAP_NS 10000
`define GSP_GAP_CYC ((`GSP_GAP_NS + `GSP_CLK_NS - 1) / `GSP_CLK_NS)
`endif

// ### common/gsp_pkg.sv
package gsp_pkg;
  typedef enum logic [1:0] {
    GSP_M_IDLE = 2'b00,
    GSP_M_SHIFT = 2'b01,
    GSP_M_GAP = 2'b10
  } gsp_mstate_t;
  typedef logic [7:0] gsp_byte_t;
endpackage

// ### common/gsp_if.sv
`timescale 1ns/1ps
interface gsp_if;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic miso;
  logic miso_oe_n;
  modport dev (input cs_n, input sclk, input mosi,
               output miso, output miso_oe_n);
  modport mst (output cs_n, output sclk, output mosi,
               input miso, input miso_oe_n);
endinterface

// ### src/gsp_master.sv
`timescale 1ns/1ps
`include "gsp_consts.svh"
module gsp_master
  import gsp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial link
  gsp_if.mst link,
  // Command port
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_read,
  input wire logic [6:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  // Answer
  output logic rsp_valid,
  output logic [7:0] rsp_rdata
);
  // ----------------------------------------
  // Transfer engine
  // ----------------------------------------
  // Single register per select; the gap covers the fast-clock limit
  localparam int HALF = `GSP_SCLK_HALF_CYC; // R3
  localparam int GAP = `GSP_GAP_CYC; // R11
  gsp_mstate_t st_reg;
  logic [13:0] cnt_reg;
  logic [4:0] edge_reg;
  logic [15:0] tx_reg;
  logic [7:0] rx_reg;
  logic rd_reg, sclk_reg, cs_reg;
  logic [2:0] mi_sy_reg;
  logic [2:0] mi_sy;
  assign mi_sy = mi_sy_reg;
  wire logic tick = (cnt_reg == 14'(HALF - 1));
  assign cmd_ready = (st_reg == GSP_M_IDLE);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= GSP_M_IDLE;
      cnt_reg <= 14'h0000;
      edge_reg <= 5'h00;
      tx_reg <= 16'h0000;
      rx_reg <= 8'h00;
      rd_reg <= 1'b0;
      sclk_reg <= 1'b1;
      cs_reg <= 1'b1;
      mi_sy_reg <= 3'h0;
      rsp_valid <= 1'b0;
      rsp_rdata <= 8'h00;
    end else begin
      mi_sy_reg <= {mi_sy_reg[1:0], link.miso};
      rsp_valid <= 1'b0;
      unique case (st_reg)
        GSP_M_IDLE: begin
          sclk_reg <= 1'b1; // R6
          if (cmd_valid) begin
            tx_reg <= {cmd_read, cmd_addr, cmd_wdata}; // R12 R13
            rd_reg <= cmd_read;
            cs_reg <= 1'b0; // R5
            cnt_reg <= 14'h0000;
            edge_reg <= 5'h00;
            st_reg <= GSP_M_SHIFT;
          end
        end
        GSP_M_SHIFT: begin
          cnt_reg <= tick ? 14'h0000 : cnt_reg + 14'h1;
          if (tick) begin
            edge_reg <= edge_reg + 5'h1;
            if (!edge_reg[0]) begin
              sclk_reg <= 1'b0; // R4
              // Data moves on falling edges; the first bit is already out
              if (edge_reg != 5'h00) tx_reg <= {tx_reg[14:0], 1'b0}; // R4
            end else begin
              sclk_reg <= 1'b1; // R4
              if (mi_sy[1] == mi_sy[2])
                rx_reg <= {rx_reg[6:0], mi_sy[2]}; // R7
              if (edge_reg == 5'h1f) st_reg <= GSP_M_GAP; // R12
            end
          end
        end
        GSP_M_GAP: begin
          // Select stays low a half period past the last rising edge
          if (cs_reg == 1'b0) begin
            cnt_reg <= tick ? 14'h0000 : cnt_reg + 14'h1;
            if (tick) begin
              cs_reg <= 1'b1; // R5 R10
              rsp_valid <= 1'b1;
              rsp_rdata <= rd_reg ? rx_reg : 8'h00; // R2
            end
          end else if (cnt_reg == 14'(GAP - 1)) begin
            st_reg <= GSP_M_IDLE; // R11
          end else begin
            cnt_reg <= cnt_reg + 14'h1;
          end
        end
        default: st_reg <= GSP_M_IDLE;
      endcase
    end
  end
  assign link.cs_n = cs_reg;
  assign link.sclk = sclk_reg;
  assign link.mosi = tx_reg[15];
endmodule // gsp_master

// ### test/gsp_link_checker.sv
`timescale 1ns/1ps
module gsp_link_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial link
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe_n
);
  // ----------------------------------------
  // Helper counters
  // ----------------------------------------
  logic sclk_q;
  logic [4:0] edge_cnt;
  logic [10:0] gap_cnt;
  // Gap counter saturates so a long idle never wraps into a false short gap
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_q <= 1'b1;
      edge_cnt <= 5'h00;
      gap_cnt <= 11'h7ff;
    end else begin
      sclk_q <= sclk;
      edge_cnt <= cs_n ? 5'h00 : edge_cnt + {4'h0, sclk & ~sclk_q};
      gap_cnt <= !cs_n ? 11'h000 : gap_cnt + {10'h0, gap_cnt != 11'h7ff};
    end
  end
  // ----------------------------------------
  // Link properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_sclk_idle_high: assert property (cs_n |-> sclk)
    else $error("sclk low while deselected");
  chk_select_mode3: assert property ($fell(cs_n) |-> sclk)
    else $error("select fell with sclk low");
  chk_sclk_half: assert property (
    $fell(sclk) |-> !sclk[*8] ##6 $rose(sclk))
    else $error("sclk low phase not 13 cycles");
  chk_mosi_hold: assert property (
    !cs_n && sclk && $past(sclk) && !$past(cs_n) |-> $stable(mosi))
    else $error("mosi moved while sclk high");
  chk_miso_hold: assert property (
    !miso_oe_n && !$past(miso_oe_n) && sclk && $past(sclk)
      |-> $stable(miso))
    else $error("miso moved while sclk high");
  chk_frame_bits: assert property ($rose(cs_n) |-> edge_cnt == 5'h10)
    else $error("frame not 16 sclk cycles");
  chk_select_gap: assert property ($fell(cs_n) |-> gap_cnt >= 11'h4e2)
    else $error("select gap too short");
  chk_miso_release: assert property (cs_n [*8] |-> miso_oe_n)
    else $error("miso driven while deselected");
endmodule // gsp_link_checker

// ### test/gyro_spi_register_port_tb.sv
`timescale 1ns/1ps
`include "gsp_consts.svh"
module gyro_spi_register_port_tb
  import gsp_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_read = 1'b0;
  logic [6:0] cmd_addr = 7'h00;
  gsp_byte_t cmd_wdata = 8'h00;
  logic sample_valid = 1'b0;
  logic [15:0] rate_x = 16'hbeef;
  logic [15:0] rate_y = 16'h1357;
  logic [11:0] temp = 12'h9a5;
  logic cmd_ready, rsp_valid, measure_mode, temp_sensor_enable, rdy_pin;
  gsp_byte_t rsp_rdata, filter_cfg, q;
  int n_mismatch = 0;
  int tests_run = 0;
  gsp_if link_if();
  gsp_device gsp_device_inst (.clk(clk), .rst(rst), .link(link_if),
    .sample_valid(sample_valid), .rate_x(rate_x), .rate_y(rate_y),
    .temp(temp), .measure_mode(measure_mode),
    .temp_sensor_enable(temp_sensor_enable), .filter_cfg(filter_cfg),
    .ready_or_analog_select_pin(rdy_pin));
  gsp_master gsp_master_inst (.clk(clk), .rst(rst), .link(link_if),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata));
  gsp_link_checker gsp_link_checker_inst (.clk(clk), .rst(rst),
    .cs_n(link_if.cs_n), .sclk(link_if.sclk), .mosi(link_if.mosi),
    .miso(link_if.miso), .miso_oe_n(link_if.miso_oe_n));
  always #4 clk = ~clk;
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string what, input gsp_byte_t got, exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic xfer(input logic rd, input logic [6:0] a, input gsp_byte_t d);
    int n;
    n = 0;
    // Master refuses during the select gap, so wait rather than queue
    while (cmd_ready !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 3000) n_mismatch++;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_read <= rd;
    cmd_addr <= a;
    cmd_wdata <= d;
    @(posedge clk);
    cmd_valid <= 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 1000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 1000) n_mismatch++;
    q = rsp_rdata;
  endtask
  function automatic gsp_byte_t exp_reset(input int a);
    logic [63:0] tbl;
    tbl = {`GSP_SERIAL_VAL, `GSP_REV_VAL, `GSP_PART_VAL, `GSP_TECH_VAL,
           `GSP_VENDOR_VAL};
    return a < 8 ? tbl[8*a +: 8] : (a == 15 ? `GSP_RSV0F_VAL : 8'h00);
  endfunction
  task automatic pulse();
    // Let the device see select high first; capture is blocked mid-frame
    repeat (8) @(posedge clk);
    sample_valid <= 1'b1;
    @(posedge clk);
    sample_valid <= 1'b0;
    repeat (4) @(negedge clk);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset_map();
    for (int a = 0; a < 19; a++) begin
      xfer(1'b1, a[6:0], 8'h00);
      check("reset map", q, exp_reset(a));
    end
  endtask
  task automatic t_ro_write();
    int al[5] = '{0, 3, 5, 12, 15};
    foreach (al[i]) xfer(1'b0, al[i][6:0], 8'ha5);
    foreach (al[i]) begin
      xfer(1'b1, al[i][6:0], 8'h00);
      check("read only", q, exp_reset(al[i]));
    end
  endtask
  task automatic t_ctrl();
    xfer(1'b0, `GSP_A_FILT, 8'hff);
    check("write answer", q, 8'h00);
    check("filter port", filter_cfg, 8'hf7);
    xfer(1'b1, `GSP_A_FILT, 8'h00);
    check("filter read", q, 8'hf7);
    xfer(1'b0, `GSP_A_SYNC, 8'h01);
    pulse();
    check("ready standby", rdy_pin, 8'h00);
    xfer(1'b0, `GSP_A_PWR, 8'h02);
    check("measure", measure_mode, 8'h01);
    check("tsm off", temp_sensor_enable, 8'h00);
    xfer(1'b1, `GSP_A_PWR, 8'h00);
    check("power read", q, 8'h02);
  endtask
  task automatic t_sample();
    logic [47:0] sv;
    sv = {4'h0, temp, rate_y, rate_x};
    xfer(1'b0, `GSP_A_PWR, 8'h03);
    check("tsm on", temp_sensor_enable, 8'h01);
    pulse();
    check("ready set", rdy_pin, 8'h01);
    for (int i = 0; i < 6; i++) begin
      xfer(1'b1, 7'h08 + i[6:0], 8'h00);
      check("sample", q, sv[8*i +: 8]);
      if (i == 0) check("ready clear", rdy_pin, 8'h00);
    end
    xfer(1'b0, `GSP_A_PWR, 8'hfc);
    check("standby", measure_mode, 8'h00);
  endtask
  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    t_reset_map();
    t_ro_write();
    t_ctrl();
    t_sample();
    tally_and_finish();
  end
  // Normal run is about 70k cycles; the limit keeps a hang under 100k
  initial begin
    #780000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule // gyro_spi_register_port_tb
